// ==== vis_consts.svh ====
`ifndef VIS_CONSTS_SVH
`define VIS_CONSTS_SVH
`define VIS_NUM_MASKABLE   23
`define VIS_VEC_WDT        16'h0004
`define VIS_VEC_PIN_BASE   16'h0006
`define VIS_VEC_STEP       16'h0002
`define VIS_VEC_BREAK      16'h003e
`define VIS_FLAGS_RESET    23'h000000
`define VIS_PRI_WDT        0
`define VIS_PRI_PIN0       1
`define VIS_PRI_SYNC0      9
`define VIS_PRI_TIMER8A    12
`define VIS_PRI_ASYNC_ERR  14
`define VIS_PRI_BASIC      17
`define VIS_PRI_CAPCMP0    18
`define VIS_PRI_CAPCMP1    19
`define VIS_PRI_SERBUS_ACC 20
`define VIS_PRI_SERBUS_EVT 21
`define VIS_PRI_ADC        22
`define VIS_PRI_W          5
`endif

// ==== vis_pkg.sv ====
package vis_pkg;
  typedef logic [15:0] vis_vector_t;
  typedef logic [4:0]  vis_prio_t;
  typedef enum logic [1:0] {
    VIS_KIND_NONE,
    VIS_KIND_NMI,
    VIS_KIND_MASKABLE,
    VIS_KIND_BREAK
  } vis_kind_t;
endpackage : vis_pkg

// ==== vis_edge_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser followed by selectable edge detection
module vis_edge_detect (
  input  wire logic core_clk, // Clock
  input  wire logic rst_n,    // Async reset, active low
  input  wire logic pin_in,   // Asynchronous pin
  input  wire logic rise_en,  // Detect rising edges
  input  wire logic fall_en,  // Detect falling edges
  output logic      edge_p    // One-cycle pulse on chosen edge
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  wire  rose;
  wire  fell;

  assign rose   = sync2_q & ~prev_q;
  assign fell   = ~sync2_q & prev_q;
  assign edge_p = (rose & rise_en) | (fell & fall_en);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
endmodule : vis_edge_detect
`default_nettype wire

// ==== vis_prio_pick.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "vis_consts.svh"
// Fixed-priority picker: lowest index wins
module vis_prio_pick #(
  parameter int N = `VIS_NUM_MASKABLE
) (
  input  wire logic [N-1:0]         req,   // Eligible requests
  output logic                      any,   // At least one request
  output vis_pkg::vis_prio_t        index, // Index of winner
  output logic [N-1:0]              onehot // One-hot winner
);
  logic [N-1:0] seen;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_scan
      if (g == 0)
      begin : g_first
        assign seen[g]   = req[g];
        assign onehot[g] = req[g];
      end
      else
      begin : g_rest
        assign seen[g]   = seen[g-1] | req[g];
        assign onehot[g] = req[g] & ~seen[g-1];
      end
    end
  endgenerate

  assign any = seen[N-1];

  always_comb
  begin
    index = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        index = vis_pkg::vis_prio_t'(i);
      end
    end
  end
endmodule : vis_prio_pick
`default_nettype wire

// ==== vis_controller.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "vis_consts.svh"
module vis_controller (
  input  wire logic                      core_clk,              // 25 MHz clock
  input  wire logic                      rst_n,                 // Async reset, active low
  input  wire logic                      wdt_overflow,          // Watchdog overflow pulse
  input  wire logic                      wdt_interval_mode,     // 1: interval mode, 0: watchdog mode 1
  input  wire logic [7:0]                pin_edge_in,           // External request pins 0..7
  input  wire logic [7:0]                pin_rise_en,           // Rising edge enables
  input  wire logic [7:0]                pin_fall_en,           // Falling edge enables
  input  wire logic [2:0]                sync_serial_done,      // Serial ports 0, 1, 3 done pulses
  input  wire logic [1:0]                timer8_match,          // 8-bit timer a, b match pulses
  input  wire logic                      async_rx_error,        // Async reception error pulse
  input  wire logic                      async_rx_done,         // Async reception end pulse
  input  wire logic                      async_tx_done,         // Async transmission end pulse
  input  wire logic                      basic_timer_match,     // Basic timer match pulse
  input  wire logic [1:0]                counter16_match,       // Compare match, channels 0 and 1
  input  wire logic [1:0]                capcmp_capture_mode,   // 1: channel in capture use
  input  wire logic [1:0]                capture_pin,           // Capture input pins 0 and 1
  input  wire logic [1:0]                capture_rise_en,       // Capture pin rising enables
  input  wire logic [1:0]                capture_fall_en,       // Capture pin falling enables
  input  wire logic                      serbus_access,         // Serial-bus data access pulse
  input  wire logic                      serbus_event,          // Serial-bus error/start/end pulse
  input  wire logic                      adc_done,              // Conversion done pulse
  input  wire logic                      software_break,        // Break instruction executed pulse
  input  wire logic [22:0]               irq_mask,              // 1 masks a maskable request
  input  wire logic                      irq_ack,               // Core takes the offered request
  output logic                           irq_valid,             // Request offered to the core
  output vis_pkg::vis_kind_t             irq_kind,              // Kind of offered request
  output vis_pkg::vis_prio_t             irq_prio,              // Priority of offered maskable
  output vis_pkg::vis_vector_t           irq_vector,            // Vector of offered request
  output logic [22:0]                    irq_pending            // Request flags
);
  localparam int N = `VIS_NUM_MASKABLE;

  logic [N-1:0]          flag_q;
  logic [N-1:0]          flag_d;
  logic                  nmi_q;
  logic                  nmi_d;
  logic                  brk_q;
  logic                  brk_d;
  logic                  valid_q;
  vis_pkg::vis_kind_t    kind_q;
  vis_pkg::vis_kind_t    kind_d;
  vis_pkg::vis_prio_t    prio_q;
  vis_pkg::vis_vector_t  vector_q;
  vis_pkg::vis_vector_t  vector_d;
  logic [N-1:0]          pick_q;
  logic [N-1:0]          set_vec;
  logic [N-1:0]          clr_vec;
  logic [N-1:0]          eligible;
  logic [N-1:0]          win_onehot;
  logic [7:0]            pin_pulse;
  logic [1:0]            cap_pulse;
  logic                  win_any;
  vis_pkg::vis_prio_t    win_index;
  wire                   take;
  wire                   take_nmi;
  wire                   take_brk;
  wire                   take_mask;
  wire [1:0]             capcmp_fire;

  // Maskable vectors are evenly spaced from the pin base, watchdog apart
  function automatic vis_pkg::vis_vector_t vec_of(input vis_pkg::vis_prio_t p);
    if (p == vis_pkg::vis_prio_t'(`VIS_PRI_WDT))
      vec_of = `VIS_VEC_WDT;
    else
      vec_of = `VIS_VEC_PIN_BASE + `VIS_VEC_STEP * vis_pkg::vis_vector_t'(p - 5'h01);
  endfunction : vec_of

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      vis_edge_detect u_pin (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (pin_edge_in[g]),
        .rise_en  (pin_rise_en[g]),
        .fall_en  (pin_fall_en[g]),
        .edge_p   (pin_pulse[g])
      );
    end
    for (g = 0; g < 2; g++)
    begin : g_cap
      vis_edge_detect u_cap (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (capture_pin[g]),
        .rise_en  (capture_rise_en[g]),
        .fall_en  (capture_fall_en[g]),
        .edge_p   (cap_pulse[g])
      );
    end
  endgenerate

  // Capture use takes the pin edge, compare use the counter match
  assign capcmp_fire = (capcmp_capture_mode & cap_pulse) | (~capcmp_capture_mode & counter16_match);

  always_comb
  begin
    set_vec = '0;
    set_vec[`VIS_PRI_WDT] = wdt_overflow & wdt_interval_mode;
    set_vec[`VIS_PRI_PIN0 +: 8] = pin_pulse;
    set_vec[`VIS_PRI_SYNC0 +: 3] = sync_serial_done;
    set_vec[`VIS_PRI_TIMER8A +: 2] = timer8_match;
    set_vec[`VIS_PRI_ASYNC_ERR +: 3] = {async_tx_done, async_rx_done, async_rx_error};
    set_vec[`VIS_PRI_BASIC] = basic_timer_match;
    set_vec[`VIS_PRI_CAPCMP0] = capcmp_fire[0];
    set_vec[`VIS_PRI_CAPCMP1] = capcmp_fire[1];
    set_vec[`VIS_PRI_SERBUS_ACC] = serbus_access;
    set_vec[`VIS_PRI_SERBUS_EVT] = serbus_event;
    set_vec[`VIS_PRI_ADC] = adc_done;
  end

  assign eligible = flag_q & ~irq_mask;

  vis_prio_pick #(
    .N (N)
  ) u_pick (
    .req    (eligible),
    .any    (win_any),
    .index  (win_index),
    .onehot (win_onehot)
  );

  assign take      = valid_q & irq_ack;
  assign take_nmi  = take & (kind_q == vis_pkg::VIS_KIND_NMI);
  assign take_brk  = take & (kind_q == vis_pkg::VIS_KIND_BREAK);
  assign take_mask = take & (kind_q == vis_pkg::VIS_KIND_MASKABLE);

  // Acknowledge clears only the flag that was offered; a new event wins
  assign clr_vec = take_mask ? pick_q : '0;
  assign flag_d  = (flag_q & ~clr_vec) | set_vec;
  assign nmi_d   = (nmi_q & ~take_nmi) | (wdt_overflow & ~wdt_interval_mode);
  assign brk_d   = (brk_q & ~take_brk) | software_break;

  // Offer order: non-maskable, break, then arbitrated maskable
  always_comb
  begin
    kind_d   = vis_pkg::VIS_KIND_NONE;
    vector_d = '0;
    if (nmi_d)
    begin
      kind_d   = vis_pkg::VIS_KIND_NMI;
      vector_d = `VIS_VEC_WDT;
    end
    else if (brk_d)
    begin
      kind_d   = vis_pkg::VIS_KIND_BREAK;
      vector_d = `VIS_VEC_BREAK;
    end
    else if (win_any && !take_mask)
    begin
      kind_d   = vis_pkg::VIS_KIND_MASKABLE;
      vector_d = vec_of(win_index);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q   <= `VIS_FLAGS_RESET;
      nmi_q    <= 1'b0;
      brk_q    <= 1'b0;
      valid_q  <= 1'b0;
      kind_q   <= vis_pkg::VIS_KIND_NONE;
      prio_q   <= '0;
      vector_q <= '0;
      pick_q   <= '0;
    end
    else
    begin
      flag_q   <= flag_d;
      nmi_q    <= nmi_d;
      brk_q    <= brk_d;
      valid_q  <= (kind_d != vis_pkg::VIS_KIND_NONE);
      kind_q   <= kind_d;
      prio_q   <= (kind_d == vis_pkg::VIS_KIND_MASKABLE) ? win_index : '0;
      vector_q <= vector_d;
      pick_q   <= (kind_d == vis_pkg::VIS_KIND_MASKABLE) ? win_onehot : '0;
    end
  end

  assign irq_valid   = valid_q;
  assign irq_kind    = kind_q;
  assign irq_prio    = prio_q;
  assign irq_vector  = vector_q;
  assign irq_pending = flag_q;
endmodule : vis_controller
`default_nettype wire

// ==== vis_controller_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module vis_controller_props (
  input wire logic                 core_clk,          // Clock
  input wire logic                 rst_n,             // Reset
  input wire logic                 wdt_overflow,      // Event
  input wire logic                 wdt_interval_mode, // Mode
  input wire logic                 software_break,    // Event
  input wire logic                 adc_done,          // Event
  input wire logic [22:0]          irq_mask,          // Masks
  input wire logic                 irq_ack,           // Take
  input wire logic                 irq_valid,         // Offer
  input wire vis_pkg::vis_kind_t   irq_kind,          // Kind
  input wire vis_pkg::vis_prio_t   irq_prio,          // Priority
  input wire vis_pkg::vis_vector_t irq_vector,        // Vector
  input wire logic [22:0]          irq_pending        // Flags
);
  logic [22:0] mask_q;
  logic [22:0] pend_q;
  logic        nmi_ev;
  assign nmi_ev = wdt_overflow & ~wdt_interval_mode;
  // Mask as seen when the offer was registered
  always_ff @(posedge core_clk) mask_q <= irq_mask;
  // Flags the winner was picked from
  always_ff @(posedge core_clk) pend_q <= irq_pending;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take_mask;
    irq_valid && irq_ack && irq_kind == vis_pkg::VIS_KIND_MASKABLE;
  endsequence
  sequence s_nmi_event;
    nmi_ev;
  endsequence
  a_nmi_raise: assert property (s_nmi_event |=> irq_kind == vis_pkg::VIS_KIND_NMI && irq_vector == 16'h0004)
    else $error("nmi not offered");
  a_nmi_hold: assert property (irq_kind == vis_pkg::VIS_KIND_NMI && !irq_ack |=> irq_kind == vis_pkg::VIS_KIND_NMI)
    else $error("nmi dropped");
  a_wdt_maskable: assert property (wdt_overflow && wdt_interval_mode |=> irq_pending[0])
    else $error("interval flag missing");
  a_break_vector: assert property (irq_kind == vis_pkg::VIS_KIND_BREAK |-> irq_valid && irq_vector == 16'h003e)
    else $error("break vector wrong");
  a_break_raise: assert property (
    software_break && !nmi_ev && irq_kind != vis_pkg::VIS_KIND_NMI |=> irq_kind == vis_pkg::VIS_KIND_BREAK)
    else $error("break not offered");
  a_mask_vector: assert property (
    irq_kind == vis_pkg::VIS_KIND_MASKABLE |-> irq_valid && irq_vector == 16'h0004 + {10'h000, irq_prio, 1'b0})
    else $error("maskable vector wrong");
  a_lowest_wins: assert property (
    irq_kind == vis_pkg::VIS_KIND_MASKABLE |-> pend_q[irq_prio] && !mask_q[irq_prio] &&
    (pend_q & ~mask_q & ((23'h000001 << irq_prio) - 23'h000001)) == 23'h000000)
    else $error("wrong maskable winner");
  a_take_gap: assert property (s_take_mask |=> irq_kind != vis_pkg::VIS_KIND_MASKABLE)
    else $error("no gap after take");
  a_adc_flag: assert property (adc_done |=> irq_pending[22])
    else $error("conversion flag missing");
endmodule : vis_controller_props
`default_nettype wire

// ==== vis_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Core side: takes an offer after wait_cyc cycles, then idles a cycle
module vis_core_model (
  input  wire logic       core_clk,  // Clock
  input  wire logic       rst_n,     // Reset
  input  wire logic       take_en,   // Accept enable
  input  wire logic [3:0] wait_cyc,  // Accept delay
  input  wire logic       irq_valid, // Offer
  output logic            irq_ack    // Accept
);
  logic [3:0] cnt_q;
  always @(negedge core_clk or negedge rst_n)
    if (!rst_n || irq_ack || !take_en || !irq_valid)
    begin
      irq_ack <= 1'b0;
      cnt_q   <= 4'h0;
    end
    else
    begin
      irq_ack <= cnt_q >= wait_cyc;
      cnt_q   <= cnt_q + 4'h1;
    end
endmodule : vis_core_model
`default_nettype wire

// ==== tb_vectored_interrupt_sources.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_vectored_interrupt_sources;
  logic core_clk, rst_n, wdt_overflow, wdt_interval_mode, async_rx_error, async_rx_done, async_tx_done, gap;
  logic basic_timer_match, serbus_access, serbus_event, adc_done, software_break, irq_ack, irq_valid, take_en;
  logic [7:0]  pin_edge_in, pin_rise_en, pin_fall_en;
  logic [2:0]  sync_serial_done;
  logic [1:0]  timer8_match, counter16_match, capcmp_capture_mode, capture_pin, capture_rise_en, capture_fall_en;
  logic [22:0] irq_mask, irq_pending, m_pend, ev;
  logic [1:0]  e_kind;
  logic [3:0]  wait_cyc;
  logic [15:0] ev16, e_vec, pvec, taken[$], exp_q[$];
  logic [31:0] lfsr;
  logic        m_nmi, m_brk, chk_on, pv;
  int          n_errors, num_checks, i;
  vis_pkg::vis_kind_t   irq_kind;
  vis_pkg::vis_prio_t   irq_prio, e_prio;
  vis_pkg::vis_vector_t irq_vector;
  vis_controller dut_u (.*);
  vis_core_model core_u (.*);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic draw();
    repeat (32) lfsr = lfsr_next(lfsr);
  endtask : draw
  task automatic drive_ev(input logic [15:0] v);
    {adc_done, serbus_event, serbus_access, counter16_match, basic_timer_match, async_tx_done, async_rx_done,
     async_rx_error, timer8_match, sync_serial_done, wdt_overflow, software_break} = v;
  endtask : drive_ev
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    #2000000;
    n_errors++;
    tally_and_finish();
  end
  // Reference flags: pins are left to the directed phase
  assign ev = {adc_done, serbus_event, serbus_access, counter16_match & ~capcmp_capture_mode, basic_timer_match,
               async_tx_done, async_rx_done, async_rx_error, timer8_match, sync_serial_done, 8'h00,
               wdt_overflow & wdt_interval_mode};
  assign e_vec = e_kind == vis_pkg::VIS_KIND_NMI ? 16'h0004 : e_kind == vis_pkg::VIS_KIND_BREAK ? 16'h003e :
                 e_kind == vis_pkg::VIS_KIND_MASKABLE ? 16'h0004 + {10'h000, e_prio, 1'b0} : 16'h0000;
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      {m_pend, m_nmi, m_brk, e_kind, e_prio} = '0;
    else
    begin
      gap = 1'b0;
      if (irq_ack && e_kind != vis_pkg::VIS_KIND_NONE)
        case (e_kind)
          vis_pkg::VIS_KIND_NMI:   m_nmi = 1'b0;
          vis_pkg::VIS_KIND_BREAK: m_brk = 1'b0;
          default:                 {m_pend[e_prio], gap} = 2'b01;
        endcase
      m_nmi  = m_nmi | (wdt_overflow & ~wdt_interval_mode);
      m_brk  = m_brk | software_break;
      e_kind = m_nmi ? vis_pkg::VIS_KIND_NMI : m_brk ? vis_pkg::VIS_KIND_BREAK : vis_pkg::VIS_KIND_NONE;
      e_prio = 5'h00;
      for (int k = 22; k >= 0; k--)
        if (!m_nmi && !m_brk && !gap && m_pend[k] && !irq_mask[k])
          {e_kind, e_prio} = {vis_pkg::VIS_KIND_MASKABLE, k[4:0]};
      // Offer arbitrates on flags held before this edge
      m_pend = m_pend | ev;
    end
  always @(negedge core_clk)
  begin
    if (rst_n && chk_on)
      check("offer", {e_kind != 2'h0, e_kind, e_prio, e_vec, m_pend},
            {irq_valid, irq_kind, irq_prio, irq_vector, irq_pending});
    if (irq_ack && pv)
      taken.push_back(pvec);
    pv   = irq_valid;
    pvec = irq_vector;
  end
  initial
  begin
    {pin_edge_in, pin_rise_en, pin_fall_en, capture_pin, capture_rise_en, capture_fall_en} = '0;
    {capcmp_capture_mode, irq_mask, wdt_interval_mode, wait_cyc, rst_n} = '0;
    {take_en, chk_on, n_errors, num_checks, lfsr} = {2'b11, 64'h0, 32'h8e12};
    drive_ev(16'h0000);
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      draw();
      if (i % 64 == 0)
        {irq_mask, take_en, wait_cyc, wdt_interval_mode} = {lfsr[22:0] & lfsr[31:9], lfsr[2:0] != 3'h0, lfsr[7:4],
                                                            lfsr[8]};
      draw();
      ev16 = lfsr[15:0] & lfsr[31:16];
      draw();
      drive_ev(ev16 & lfsr[15:0] & lfsr[31:16]);
      @(negedge core_clk);
    end
    drive_ev(16'h0000);
    {rst_n, chk_on, irq_mask, take_en, wait_cyc, capcmp_capture_mode} = {2'b00, 23'h7fffff, 5'h10, 2'b11};
    @(negedge core_clk);
    rst_n = 1'b1;
    for (int k = 1; k <= 8; k++)
      exp_q.push_back(16'h0004 + 16'(2 * k));
    exp_q.push_back(16'h0028);
    exp_q.push_back(16'h002a);
    for (i = 0; i < 2; i++)
    begin
      {pin_rise_en, capture_rise_en, pin_fall_en, capture_fall_en} = i ? 20'h003ff : 20'hffc00;
      {pin_edge_in, capture_pin} = i ? 10'h000 : 10'h3ff;
      repeat (8) @(negedge core_clk);
      check("pin flags", 23'h0c01fe, irq_pending);
      taken.delete();
      irq_mask = '0;
      repeat (40) @(negedge core_clk);
      irq_mask = '1;
      check("taken count", 10, taken.size());
      foreach (exp_q[k])
        check("taken vector", exp_q[k], taken[k]);
    end
    tally_and_finish();
  end
endmodule : tb_vectored_interrupt_sources
bind vis_controller vis_controller_props props_u (.*);
`default_nettype wire
